// ===== alt_select_decode.v
`timescale 1ns/1ps
`default_nettype none
`include "input_port_defines.vh"

module alt_select_decode (
    input  wire [`NUM_ALT_PINS-1:0] i_alt_select_low_bits,
    input  wire [`NUM_ALT_PINS-1:0] i_alt_select_high_bits,
    output wire [`NUM_ALT_PINS-1:0] o_gpio_sel,
    output wire [`NUM_ALT_PINS-1:0] o_alt1_sel,
    output wire [`NUM_ALT_PINS-1:0] o_alt2_sel,
    output wire [`NUM_ALT_PINS-1:0] o_alt3_sel
);

    genvar g;
    generate
        for (g = 0; g < `NUM_ALT_PINS; g = g + 1) begin : g_pin
            wire [1:0] code;
            assign code = {i_alt_select_high_bits[g],
                           i_alt_select_low_bits[g]};
            assign o_gpio_sel[g] = (code == `ALT_GPIO);
            assign o_alt1_sel[g] = (code == `ALT_FUNC1);
            assign o_alt2_sel[g] = (code == `ALT_FUNC2);
            assign o_alt3_sel[g] = (code == `ALT_FUNC3);
        end
    endgenerate

endmodule // alt_select_decode
`default_nettype wire

// ===== input_only_port_control.v
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "input_port_defines.vh"

module input_only_port_control (
    input  wire                     i_clk,
    input  wire                     i_resetn,
    // axi4-lite write address
    input  wire [7:0]               i_s_axi_awaddr,
    input  wire [2:0]               i_s_axi_awprot,
    input  wire                     i_s_axi_awvalid,
    output wire                     o_s_axi_awready,
    // axi4-lite write data
    input  wire [31:0]              i_s_axi_wdata,
    input  wire [3:0]               i_s_axi_wstrb,
    input  wire                     i_s_axi_wvalid,
    output wire                     o_s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]               o_s_axi_bresp,
    output reg                      o_s_axi_bvalid,
    input  wire                     i_s_axi_bready,
    // axi4-lite read address
    input  wire [7:0]               i_s_axi_araddr,
    input  wire [2:0]               i_s_axi_arprot,
    input  wire                     i_s_axi_arvalid,
    output wire                     o_s_axi_arready,
    // axi4-lite read data
    output reg  [31:0]              o_s_axi_rdata,
    output reg  [1:0]               o_s_axi_rresp,
    output reg                      o_s_axi_rvalid,
    input  wire                     i_s_axi_rready,
    // pads
    input  wire [`NUM_PINS-1:0]     i_pin_level,
    output wire [`NUM_PINS-1:0]     o_pad_out_en,
    output wire [`NUM_PINS-1:0]     o_pad_input_en,
    output wire [`NUM_PINS-1:0]     o_pad_pull_up_en,
    output wire [`NUM_PINS-1:0]     o_pad_pull_down_en,
    // consumers of the pin levels
    output reg  [`NUM_PINS-1:0]     o_periph_in,
    output wire [`NUM_PINS-1:0]     o_analog_sel,
    output reg                      o_crystal_oscillator_pins_in,
    // neighbouring output port select decode
    input  wire [`NUM_ALT_PINS-1:0] i_alt_select_low_bits,
    input  wire [`NUM_ALT_PINS-1:0] i_alt_select_high_bits,
    output wire [`NUM_ALT_PINS-1:0] o_alt_gpio_sel,
    output wire [`NUM_ALT_PINS-1:0] o_alt1_sel,
    output wire [`NUM_ALT_PINS-1:0] o_alt2_sel,
    output wire [`NUM_ALT_PINS-1:0] o_alt3_sel
);

    localparam [1:0] WS_COLLECT = 2'b01;
    localparam [1:0] WS_RESP    = 2'b10;
    localparam [1:0] RS_IDLE    = 2'b01;
    localparam [1:0] RS_DATA    = 2'b10;
    // pins 0 and 2..5 exist
    localparam [7:0] PIN_MASK_W = `PIN_MASK;

    reg  [1:0]  wstate_r;
    reg  [1:0]  wstate_nxt;
    reg         aw_got_r;
    reg         w_got_r;
    reg  [7:0]  awaddr_r;
    reg  [31:0] wdata_r;
    reg  [3:0]  wstrb_r;
    reg  [1:0]  rstate_r;
    reg  [1:0]  rstate_nxt;

    reg  [7:0]  pin_levels_r;
    reg  [7:0]  driver_ctrl_r;
    reg  [7:0]  pull_select_r;
    reg  [7:0]  pull_enable_r;

    wire        aw_hs;
    wire        w_hs;
    wire        ar_hs;
    wire        aw_have;
    wire        w_have;
    wire [7:0]  wr_addr;
    wire [31:0] wr_data;
    wire [3:0]  wr_strb;
    wire        wr_fire;
    wire        wr_hit;
    wire [7:0]  wr_byte;
    reg  [7:0]  rd_byte;
    reg         rd_hit;
    wire [`NUM_PINS-1:0] in_en;
    wire [`NUM_PINS-1:0] pin_sample;

    wire        wr_en;
    wire        wr_sel_lvl;
    wire        wr_sel_drv;
    wire        wr_sel_psel;
    wire        wr_sel_pen;
    wire [1:0]  wr_resp;
    wire [1:0]  rd_resp;
    wire [31:0] rd_word;

    // write channel handshakes, address and data in either order
    assign o_s_axi_awready = (wstate_r == WS_COLLECT) && !aw_got_r;
    assign o_s_axi_wready  = (wstate_r == WS_COLLECT) && !w_got_r;
    assign aw_hs   = i_s_axi_awvalid && o_s_axi_awready;
    assign w_hs    = i_s_axi_wvalid && o_s_axi_wready;
    assign aw_have = aw_got_r || aw_hs;
    assign w_have  = w_got_r || w_hs;
    assign wr_addr = aw_got_r ? awaddr_r : i_s_axi_awaddr;
    assign wr_data = w_got_r ? wdata_r : i_s_axi_wdata;
    assign wr_strb = w_got_r ? wstrb_r : i_s_axi_wstrb;
    assign wr_fire = (wstate_r == WS_COLLECT) && aw_have && w_have;
    // write address decode
    assign wr_sel_lvl  = (wr_addr == `OFS_PIN_LEVELS);
    assign wr_sel_drv  = (wr_addr == `OFS_DRIVER_CTRL);
    assign wr_sel_psel = (wr_addr == `OFS_PULL_SELECT);
    assign wr_sel_pen  = (wr_addr == `OFS_PULL_ENABLE);
    assign wr_hit  = wr_sel_lvl || wr_sel_drv || wr_sel_psel || wr_sel_pen;
    // unmapped offsets answer an error
    assign wr_resp = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    assign wr_en   = wr_fire && wr_strb[0];
    assign wr_byte = wr_data[7:0] & `PIN_MASK;

    always @* begin
        wstate_nxt = wstate_r;
        case (wstate_r)
            WS_COLLECT: begin
                if (wr_fire) begin
                    wstate_nxt = WS_RESP;
                end
            end
            WS_RESP: begin
                if (i_s_axi_bready) begin
                    wstate_nxt = WS_COLLECT;
                end
            end
            default: begin
                wstate_nxt = WS_COLLECT;
            end
        endcase
    end

    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wstate_r       <= WS_COLLECT;
            aw_got_r       <= 1'b0;
            w_got_r        <= 1'b0;
            awaddr_r       <= 8'h00;
            wdata_r        <= 32'h0000_0000;
            wstrb_r        <= 4'h0;
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp  <= `RESP_OKAY;
        end else begin
            wstate_r <= wstate_nxt;
            if (aw_hs) begin
                awaddr_r <= i_s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_r <= i_s_axi_wdata;
                wstrb_r <= i_s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_got_r       <= 1'b0;
                w_got_r        <= 1'b0;
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp  <= wr_resp;
            end else begin
                if (aw_hs) begin
                    aw_got_r <= 1'b1;
                end
                if (w_hs) begin
                    w_got_r <= 1'b1;
                end
                if (o_s_axi_bvalid && i_s_axi_bready) begin
                    o_s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    // control registers
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            driver_ctrl_r <= `RST_DRIVER_CTRL;
            pull_select_r <= `RST_PULL_SELECT;
            pull_enable_r <= `RST_PULL_ENABLE;
        end else if (wr_en) begin
            case (wr_addr)
                `OFS_DRIVER_CTRL: begin
                    driver_ctrl_r <= wr_byte;
                end
                `OFS_PULL_SELECT: begin
                    pull_select_r <= wr_byte;
                end
                `OFS_PULL_ENABLE: begin
                    pull_enable_r <= wr_byte;
                end
                default: begin
                    driver_ctrl_r <= driver_ctrl_r;
                end
            endcase
        end
    end

    // per-pin pad controls
    genvar p;
    generate
        for (p = 0; p < `NUM_PINS; p = p + 1) begin : g_pad
            assign in_en[p] = PIN_MASK_W[p] & ~driver_ctrl_r[p];
            assign pin_sample[p] = i_pin_level[p] & in_en[p];
            assign o_analog_sel[p] = PIN_MASK_W[p];
            assign o_pad_out_en[p] = 1'b0;
            assign o_pad_pull_up_en[p] =
                PIN_MASK_W[p] & pull_enable_r[p] & pull_select_r[p];
            assign o_pad_pull_down_en[p] =
                PIN_MASK_W[p] & pull_enable_r[p] & ~pull_select_r[p];
        end
    endgenerate

    assign o_pad_input_en = in_en;

    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pin_levels_r <= `RST_PIN_LEVELS;
        end else begin
            pin_levels_r <= {2'b00, pin_sample};
        end
    end

    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_periph_in                  <= 6'h00;
            o_crystal_oscillator_pins_in <= 1'b0;
        end else begin
            o_periph_in                  <= pin_sample;
            o_crystal_oscillator_pins_in <= i_pin_level[0];
        end
    end

    // read channel, one request at a time
    assign o_s_axi_arready = (rstate_r == RS_IDLE);
    assign ar_hs = i_s_axi_arvalid && o_s_axi_arready;

    // read state: idle or data held
    always @* begin
        rstate_nxt = rstate_r;
        case (rstate_r)
            RS_IDLE: begin
                if (ar_hs) begin
                    rstate_nxt = RS_DATA;
                end
            end
            RS_DATA: begin
                if (i_s_axi_rready) begin
                    rstate_nxt = RS_IDLE;
                end
            end
            default: begin
                rstate_nxt = RS_IDLE;
            end
        endcase
    end

    // read state register
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rstate_r <= RS_IDLE;
        end else begin
            rstate_r <= rstate_nxt;
        end
    end

    always @* begin
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        case (i_s_axi_araddr)
            `OFS_PIN_LEVELS: begin
                rd_byte = pin_levels_r;
            end
            `OFS_DRIVER_CTRL: begin
                rd_byte = driver_ctrl_r;
            end
            `OFS_PULL_SELECT: begin
                rd_byte = pull_select_r;
            end
            `OFS_PULL_ENABLE: begin
                rd_byte = pull_enable_r;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    assign rd_word = {24'h00_0000, rd_byte & PIN_MASK_W};
    assign rd_resp = rd_hit ? `RESP_OKAY : `RESP_SLVERR;

    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata  <= 32'h0000_0000;
            o_s_axi_rresp  <= `RESP_OKAY;
        end else if (ar_hs) begin
            o_s_axi_rvalid <= 1'b1;
            o_s_axi_rdata  <= rd_word;
            o_s_axi_rresp  <= rd_resp;
        end else if (i_s_axi_rready) begin
            o_s_axi_rvalid <= 1'b0;
        end
    end

    alt_select_decode u_alt_decode (
        .i_alt_select_low_bits  (i_alt_select_low_bits),
        .i_alt_select_high_bits (i_alt_select_high_bits),
        .o_gpio_sel             (o_alt_gpio_sel),
        .o_alt1_sel             (o_alt1_sel),
        .o_alt2_sel             (o_alt2_sel),
        .o_alt3_sel             (o_alt3_sel)
    );

endmodule // input_only_port_control
`default_nettype wire

// ===== input_only_port_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "input_port_defines.vh"
module input_only_port_control_test;
    logic        i_clk, i_resetn, i_s_axi_awvalid, i_s_axi_wvalid;
    logic        i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready;
    logic        o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
    logic        o_s_axi_arready, o_s_axi_rvalid, o_crystal_oscillator_pins_in;
    logic [7:0]  i_s_axi_awaddr, i_s_axi_araddr;
    logic [2:0]  i_s_axi_awprot, i_s_axi_arprot;
    logic [3:0]  i_s_axi_wstrb;
    logic [31:0] i_s_axi_wdata, o_s_axi_rdata, v;
    logic [1:0]  o_s_axi_bresp, o_s_axi_rresp, r;
    logic [5:0]  i_pin_level, o_pad_out_en, o_pad_input_en, o_analog_sel;
    logic [5:0]  o_pad_pull_up_en, o_pad_pull_down_en, o_periph_in, lvl;
    logic [4:0]  i_alt_select_low_bits, i_alt_select_high_bits;
    logic [4:0]  o_alt_gpio_sel, o_alt1_sel, o_alt2_sel, o_alt3_sel;
    int          n_fail = 0, checked = 0;
    typedef struct packed {
        logic [7:0] a; logic [31:0] d; logic [3:0] s; logic [7:0] e;
        logic [1:0] rs;
    } row_t;
    row_t rows [7] = '{
        '{8'h14, 32'h0000_0000, 4'hF, 8'h00, `RESP_OKAY},
        '{8'h10, 32'h0000_003D, 4'hF, 8'h2D, `RESP_OKAY},
        '{8'h28, 32'h0000_003D, 4'hF, 8'h3D, `RESP_OKAY},
        '{8'h2C, 32'h0000_0015, 4'hF, 8'h15, `RESP_OKAY},
        '{8'h2C, 32'h0000_003D, 4'h0, 8'h15, `RESP_OKAY},
        '{8'h28, 32'h0000_0000, 4'hF, 8'h00, `RESP_OKAY},
        '{8'h24, 32'h0000_003D, 4'hF, 8'h00, `RESP_SLVERR}};
    input_only_port_control DUT (.*);
    pin_source pins (.i_clk(i_clk), .i_level(lvl), .o_pin(i_pin_level));
    task check(input string nm, input logic [31:0] seen, input logic [31:0] e);
        checked++;
        if (seen !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, seen);
        end
    endtask
    task give_verdict;
        if (n_fail == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task wr(input [7:0] a, input [31:0] d, input [3:0] s);
        @(posedge i_clk);
        i_s_axi_awaddr <= a; i_s_axi_wdata <= d; i_s_axi_wstrb <= s;
        i_s_axi_awvalid <= 1'b1; i_s_axi_wvalid <= 1'b1; i_s_axi_bready <= 1'b1;
        do begin
            @(posedge i_clk);
            if (i_s_axi_awvalid && o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
            if (i_s_axi_wvalid && o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
        end while (!o_s_axi_bvalid);
        r = o_s_axi_bresp;
        i_s_axi_bready <= 1'b0;
    endtask
    task rd(input [7:0] a);
        @(posedge i_clk);
        i_s_axi_araddr <= a; i_s_axi_arvalid <= 1'b1; i_s_axi_rready <= 1'b1;
        do begin
            @(posedge i_clk);
            if (i_s_axi_arvalid && o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
        end while (!o_s_axi_rvalid);
        v = o_s_axi_rdata; r = o_s_axi_rresp;
        i_s_axi_rready <= 1'b0;
    endtask
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    initial begin
        #200us;
        n_fail++;
        give_verdict();
    end
    initial begin
        {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid} = 0;
        {i_s_axi_rready, i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata} = 0;
        {i_s_axi_awprot, i_s_axi_arprot, i_s_axi_wstrb} = 0;
        {i_alt_select_low_bits, i_alt_select_high_bits} = 0;
        i_resetn = 1'b0;
        lvl = 6'h2D;
        repeat (20) @(posedge i_clk);
        i_resetn <= 1'b1;
        foreach (rows[k]) begin
            wr(rows[k].a, rows[k].d, rows[k].s);
            check("bresp", r, rows[k].rs);
            rd(rows[k].a);
            check("rdata", v, rows[k].e);
            check("rresp", r, rows[k].rs);
        end
        check("pull down", o_pad_pull_down_en, 6'h15);
        check("pull up", o_pad_pull_up_en, 6'h00);
        check("input enable", o_pad_input_en, 6'h3D);
        check("crystal high", o_crystal_oscillator_pins_in, 1'b1);
        @(posedge i_clk);
        lvl <= 6'h12;
        repeat (2) @(posedge i_clk);
        check("peripheral", o_periph_in, 6'h10);
        check("crystal", o_crystal_oscillator_pins_in, 1'b0);
        check("analog", o_analog_sel, 6'h3D);
        wr(8'h28, 32'h0000_003D, 4'hF);
        check("pull up set", o_pad_pull_up_en, 6'h15);
        for (int k = 0; k < 4; k++) begin
            @(posedge i_clk);
            i_alt_select_low_bits <= {5{k[0]}};
            i_alt_select_high_bits <= {5{k[1]}};
            @(posedge i_clk);
            check("alt", {o_alt3_sel, o_alt2_sel, o_alt1_sel, o_alt_gpio_sel},
                  32'h0000_001F << (5 * k));
        end
        check("out enable", o_pad_out_en, 6'h00);
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_resetn <= 1'b1;
        rd(8'h14);
        check("driver reset", v, 32'h0000_003D);
        rd(8'h28);
        check("select reset", v, 32'h0000_003D);
        rd(8'h2C);
        check("enable reset", v, 32'h0000_0000);
        rd(8'h10);
        check("levels gated", v, 32'h0000_0000);
        check("input off", o_pad_input_en, 6'h00);
        give_verdict();
    end
endmodule // input_only_port_control_test
`default_nettype wire

// ===== input_port_defines.vh
`ifndef INPUT_PORT_DEFINES_VH
`define INPUT_PORT_DEFINES_VH

// register byte offsets
`define OFS_PIN_LEVELS      8'h10
`define OFS_DRIVER_CTRL     8'h14
`define OFS_PULL_SELECT     8'h28
`define OFS_PULL_ENABLE     8'h2C

// implemented pins 0,2,3,4,5; bits 1,6,7 read zero
`define PIN_MASK            8'h3D
`define RESERVED_BIT        6
`define NUM_PINS            6
`define NUM_ALT_PINS        5

// reset values
`define RST_PIN_LEVELS      8'h00
`define RST_DRIVER_CTRL     8'h3D
`define RST_PULL_SELECT     8'hBF
`define RST_PULL_ENABLE     8'h00

// axi responses
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10

// alternate select encodings
`define ALT_GPIO            2'b00
`define ALT_FUNC1           2'b01
`define ALT_FUNC2           2'b10
`define ALT_FUNC3           2'b11

`endif

// ===== pin_source.sv
`timescale 1ns/1ps
`default_nettype none
module pin_source (
    input  wire logic       i_clk,
    input  wire logic [5:0] i_level,
    output var  logic [5:0] o_pin
);
    logic tog = 1'b0;
    always @(posedge i_clk) begin
        tog <= ~tog;
    end
    assign o_pin = {i_level[5:2], tog, i_level[0]};
endmodule // pin_source
`default_nettype wire

// ===== port_checker_props.sv
`timescale 1ns/1ps
`default_nettype none
module port_checker (
    input wire logic        i_clk,
    input wire logic        i_resetn,
    input wire logic        i_s_axi_awvalid,
    input wire logic        o_s_axi_awready,
    input wire logic        i_s_axi_wvalid,
    input wire logic        o_s_axi_wready,
    input wire logic        o_s_axi_bvalid,
    input wire logic        i_s_axi_arvalid,
    input wire logic        o_s_axi_arready,
    input wire logic        o_s_axi_rvalid,
    input wire logic [31:0] o_s_axi_rdata,
    input wire logic [5:0]  i_pin_level,
    input wire logic [5:0]  o_pad_out_en,
    input wire logic [5:0]  o_pad_input_en,
    input wire logic [5:0]  o_periph_in,
    input wire logic [4:0]  i_alt_select_low_bits,
    input wire logic [4:0]  i_alt_select_high_bits,
    input wire logic [4:0]  o_alt_gpio_sel,
    input wire logic [4:0]  o_alt1_sel,
    input wire logic [4:0]  o_alt3_sel
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    property p_no_drive; o_pad_out_en == 6'h00; endproperty
    a_no_drive: assert property (p_no_drive)
        else $error("pad output enabled");
    property p_alt13;
        o_alt1_sel == (i_alt_select_low_bits & ~i_alt_select_high_bits) &&
        o_alt3_sel == (i_alt_select_low_bits & i_alt_select_high_bits);
    endproperty
    a_alt13: assert property (p_alt13)
        else $error("alternate decode wrong");
    property p_alt_gpio;
        o_alt_gpio_sel == ~(i_alt_select_low_bits | i_alt_select_high_bits);
    endproperty
    a_alt_gpio: assert property (p_alt_gpio)
        else $error("gpio decode wrong");
    property p_reserved;
        o_s_axi_rvalid |-> (o_s_axi_rdata & 32'hFFFF_FFC2) == 32'h0000_0000;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bit reads one");
    property p_periph;
        o_periph_in == ($past(i_pin_level) & $past(o_pad_input_en));
    endproperty
    a_periph: assert property (p_periph)
        else $error("peripheral input wrong");
    property p_pad_change; $changed(o_pad_input_en) |-> o_s_axi_bvalid;
    endproperty
    a_pad_change: assert property (p_pad_change)
        else $error("input enable moved without write");
    property p_read_lat; i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid;
    endproperty
    a_read_lat: assert property (p_read_lat)
        else $error("read answer late");
    property p_write_resp;
        i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
        |=> o_s_axi_bvalid;
    endproperty
    a_write_resp: assert property (p_write_resp)
        else $error("write answer late");
endmodule // port_checker
bind input_only_port_control port_checker chk (.*);
`default_nettype wire
